// ==== hw/gmux_regs.svh ====
// Register offsets, field codes and reset values of the pin mux
`ifndef GMUX_REGS_SVH
`define GMUX_REGS_SVH
`define GMUX_NPINS      9
`define GMUX_OFS_SEL    8'h00
`define GMUX_OFS_OUT    8'h04
`define GMUX_OFS_OE     8'h08
`define GMUX_OFS_IN     8'h0c
`define GMUX_OFS_SWEN   8'h10
`define GMUX_OFS_SWEVT  8'h14
`define GMUX_OFS_STRAP  8'h18
`define GMUX_OFS_PDRV   8'h1c
`define GMUX_FN_ALT1    2'h1
`define GMUX_FN_ALT2    2'h2
`define GMUX_RST_SEL    18'h00000
`define GMUX_RST_PIN    9'h000
`define GMUX_RST_NIB    4'h0
`define GMUX_STRAP_W    13
`define GMUX_STRAP_DLY  2'h3
`define GMUX_RESP_OKAY  2'h0
`define GMUX_RESP_SLVERR 2'h2
`endif

// ==== hw/gmux_pkg.sv ====
// Types shared by the pin mux and its bench
`include "gmux_regs.svh"
`default_nettype none
package gmux_pkg;
  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } gmux_axi_req_type;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } gmux_axi_rsp_type;
  typedef struct packed {
    logic [`GMUX_NPINS-1:0] o;
    logic [`GMUX_NPINS-1:0] oe;
  } gmux_pin_type;
  typedef struct packed {
    gmux_axi_rsp_type          rsp;
    logic                      aw_got;
    logic                      w_got;
    logic [31:0]               awaddr;
    logic [31:0]               wdata;
    logic [3:0]                wstrb;
    logic [2*`GMUX_NPINS-1:0]  sel;
    logic [`GMUX_NPINS-1:0]    gout;
    logic [`GMUX_NPINS-1:0]    goe;
    logic [3:0]                swo_en;
    logic [3:0]                swo_sticky;
    logic [3:0]                part_drv;
    logic [`GMUX_NPINS-1:0]    sync1;
    logic [`GMUX_NPINS-1:0]    sync2;
    logic [3:0]                prev;
    logic [`GMUX_STRAP_W-1:0]  strap_s1;
    logic [`GMUX_STRAP_W-1:0]  strap_s2;
    logic [1:0]                strap_cnt;
    logic [`GMUX_STRAP_W-1:0]  strap;
    gmux_pin_type              pins;
    logic [3:0]                part_rst_n;
    logic                      irq_n;
    logic [3:0]                swo_evt;
  } gmux_state_type;
endpackage : gmux_pkg
`default_nettype wire

// ==== hw/gmux_top.sv ====
// General purpose pin alternate function mux with AXI4-Lite registers
// How it works
// - Each of nine pins selects plain I/O, first or second alternate.
// - Pins 0-3 first alternate are two-way partition 0-3 resets.
// - Second alternate: pin 0 port 16 link up, pin 1 link active.
// - Second alternate: pin 2 port 4 link up, pin 3 link active.
// - Second alternate: pin 4 port 0 link up, pin 5 link active.
// - Second alternate: pin 7 port 8 link up, pin 8 link active.
// - Enabled switchover input signals an event on either edge.
// - Switchover 0..3 on pin 4 alt1, 6 alt1, 7 alt1, 6 alt2.
// - Pin 5 first alternate drives the hot-plug event output.
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
`include "gmux_regs.svh"
`default_nettype none
module gmux_top #(
  parameter int NUM_PINS = `GMUX_NPINS
) (
  // Clock and fundamental reset
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  // Register bus
  input  wire gmux_pkg::gmux_axi_req_type axi_req,
  output var  gmux_pkg::gmux_axi_rsp_type axi_rsp,
  // Pins
  input  wire logic [NUM_PINS-1:0]      gpio_i,
  output var  gmux_pkg::gmux_pin_type   gpio_pin,
  // Core side, index 0..3 = ports 16, 4, 0, 8
  input  wire logic [3:0]               link_up,
  input  wire logic [3:0]               link_active,
  input  wire logic                     hotplug_event,
  output logic [3:0]                    partition_reset_n,
  output logic [3:0]                    switchover_event,
  output logic                          expander_irq_n,
  // Straps
  input  wire logic [4:0]               stack2_config_strap,
  input  wire logic [4:0]               stack3_config_strap,
  input  wire logic [1:0]               port_clocking_select,
  input  wire logic                     refclk_freq_select,
  output logic [4:0]                    stack2_cfg,
  output logic [4:0]                    stack3_cfg,
  output logic [1:0]                    port_clk_mode,
  output logic                          refclk_sel
);
  if (NUM_PINS != `GMUX_NPINS) begin : g_chk
    $error("gmux_top: pin mapping is fixed at nine pins");
  end

  gmux_pkg::gmux_state_type st_ff;
  gmux_pkg::gmux_state_type nxt_st;

  logic                    aw_hs;
  logic                    w_hs;
  logic                    ar_hs;
  logic [31:0]             waddr;
  logic [31:0]             wdat;
  logic [31:0]             wm;
  logic [31:0]             rd;
  logic                    rok;
  logic                    wok;
  logic [1:0]              fn;
  logic [NUM_PINS-1:0]     stat;
  logic [3:0]              lvl;
  logic [3:0]              swsel;
  logic [3:0]              clr;

  always_comb begin : comb
    nxt_st = st_ff;
    // Status levels, driven low while true
    // active low status
    stat = {link_active[3], link_up[3], 1'b0, link_active[2],
            link_up[2], link_active[1], link_up[1], link_active[0],
            link_up[0]};
    // Pins are asynchronous: two flops before any use
    nxt_st.sync1    = gpio_i;
    nxt_st.sync2    = st_ff.sync1;
    nxt_st.strap_s1 = {refclk_freq_select, port_clocking_select,
                       stack3_config_strap, stack2_config_strap};
    nxt_st.strap_s2 = st_ff.strap_s1;
    // straps sampled once, after the synchroniser has filled
    if (st_ff.strap_cnt != `GMUX_STRAP_DLY) begin
      nxt_st.strap_cnt = st_ff.strap_cnt + 2'h1;
      if (st_ff.strap_cnt + 2'h1 == `GMUX_STRAP_DLY) begin
        nxt_st.strap = st_ff.strap_s2;
      end
    end
    for (int i = 0; i < NUM_PINS; i++) begin
      fn = st_ff.sel[2*i +: 2];
      nxt_st.pins.o[i]  = st_ff.gout[i];
      nxt_st.pins.oe[i] = st_ff.goe[i];
      if (fn == `GMUX_FN_ALT1) begin
        nxt_st.pins.o[i]  = 1'b0;
        nxt_st.pins.oe[i] = 1'b0;
        if (i < 4) begin
          nxt_st.pins.oe[i] = st_ff.part_drv[i];
        end else if (i == 5) begin
          nxt_st.pins.o[i]  = ~hotplug_event;
          nxt_st.pins.oe[i] = 1'b1;
        end
      end else if (fn == `GMUX_FN_ALT2) begin
        nxt_st.pins.o[i]  = ~stat[i];
        nxt_st.pins.oe[i] = (i != 6);
      end
    end
    // partition reset seen from the pin
    for (int k = 0; k < 4; k++) begin
      nxt_st.part_rst_n[k] = !(st_ff.sel[2*k +: 2] == `GMUX_FN_ALT1
                               && !st_ff.sync2[k]);
    end
    // expander interrupt passes only in its function
    nxt_st.irq_n = (st_ff.sel[17:16] == `GMUX_FN_ALT1) ? st_ff.sync2[8]
                                                       : 1'b1;
    lvl   = {st_ff.sync2[6], st_ff.sync2[7], st_ff.sync2[6],
             st_ff.sync2[4]};
    swsel = {st_ff.sel[13:12] == `GMUX_FN_ALT2,
             st_ff.sel[15:14] == `GMUX_FN_ALT1,
             st_ff.sel[13:12] == `GMUX_FN_ALT1,
             st_ff.sel[9:8]   == `GMUX_FN_ALT1};
    // Tracking all lines avoids a false edge when a pin is selected
    nxt_st.prev = lvl;
    nxt_st.swo_evt = swsel & st_ff.swo_en & (lvl ^ st_ff.prev);
    // Write channel
    aw_hs = axi_req.awvalid & st_ff.rsp.awready;
    w_hs  = axi_req.wvalid & st_ff.rsp.wready;
    waddr = aw_hs ? axi_req.awaddr : st_ff.awaddr;
    wdat  = w_hs ? axi_req.wdata : st_ff.wdata;
    wm    = w_hs ? {{8{axi_req.wstrb[3]}}, {8{axi_req.wstrb[2]}},
                    {8{axi_req.wstrb[1]}}, {8{axi_req.wstrb[0]}}}
                 : {{8{st_ff.wstrb[3]}}, {8{st_ff.wstrb[2]}},
                    {8{st_ff.wstrb[1]}}, {8{st_ff.wstrb[0]}}};
    wdat  = wdat & wm;
    if (aw_hs) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.awaddr = axi_req.awaddr;
    end
    if (w_hs) begin
      nxt_st.w_got = 1'b1;
      nxt_st.wdata = axi_req.wdata;
      nxt_st.wstrb = axi_req.wstrb;
    end
    if (st_ff.rsp.bvalid && axi_req.bready) begin
      nxt_st.rsp.bvalid = 1'b0;
    end
    clr = 4'h0;
    wok = 1'b0;
    if ((st_ff.aw_got | aw_hs) && (st_ff.w_got | w_hs)
        && !st_ff.rsp.bvalid) begin
      nxt_st.aw_got     = 1'b0;
      nxt_st.w_got      = 1'b0;
      nxt_st.rsp.bvalid = 1'b1;
      wok = (waddr[31:8] == 24'h0) && (waddr[1:0] == 2'h0);
      case (waddr[7:0])
        `GMUX_OFS_SEL:
          nxt_st.sel = (st_ff.sel & ~wm[17:0]) | wdat[17:0];
        `GMUX_OFS_OUT:
          nxt_st.gout = (st_ff.gout & ~wm[8:0]) | wdat[8:0];
        `GMUX_OFS_OE:
          nxt_st.goe = (st_ff.goe & ~wm[8:0]) | wdat[8:0];
        `GMUX_OFS_SWEN:
          nxt_st.swo_en = (st_ff.swo_en & ~wm[3:0]) | wdat[3:0];
        `GMUX_OFS_SWEVT:
          clr = wdat[3:0];
        `GMUX_OFS_PDRV:
          nxt_st.part_drv = (st_ff.part_drv & ~wm[3:0]) | wdat[3:0];
        `GMUX_OFS_IN, `GMUX_OFS_STRAP: ;
        default:
          wok = 1'b0;
      endcase
      if (!wok) begin
        nxt_st.sel      = st_ff.sel;
        nxt_st.gout     = st_ff.gout;
        nxt_st.goe      = st_ff.goe;
        nxt_st.swo_en   = st_ff.swo_en;
        nxt_st.part_drv = st_ff.part_drv;
        clr             = 4'h0;
      end
      nxt_st.rsp.bresp = wok ? `GMUX_RESP_OKAY : `GMUX_RESP_SLVERR;
    end
    // A new event wins over a clear in the same cycle
    nxt_st.swo_sticky = (st_ff.swo_sticky & ~clr) | nxt_st.swo_evt;
    nxt_st.rsp.awready = !nxt_st.aw_got && !nxt_st.rsp.bvalid;
    nxt_st.rsp.wready  = !nxt_st.w_got && !nxt_st.rsp.bvalid;
    // Read channel
    ar_hs = axi_req.arvalid & st_ff.rsp.arready;
    rok   = (axi_req.araddr[31:8] == 24'h0)
            && (axi_req.araddr[1:0] == 2'h0);
    rd    = 32'h0;
    case (axi_req.araddr[7:0])
      `GMUX_OFS_SEL:   rd[17:0] = st_ff.sel;
      `GMUX_OFS_OUT:   rd[8:0]  = st_ff.gout;
      `GMUX_OFS_OE:    rd[8:0]  = st_ff.goe;
      `GMUX_OFS_IN:    rd[8:0]  = st_ff.sync2;
      `GMUX_OFS_SWEN:  rd[3:0]  = st_ff.swo_en;
      `GMUX_OFS_SWEVT: rd[3:0]  = st_ff.swo_sticky;
      `GMUX_OFS_STRAP: rd[12:0] = st_ff.strap;
      `GMUX_OFS_PDRV:  rd[3:0]  = st_ff.part_drv;
      default:         rok      = 1'b0;
    endcase
    if (st_ff.rsp.rvalid && axi_req.rready) begin
      nxt_st.rsp.rvalid = 1'b0;
    end
    if (ar_hs) begin
      nxt_st.rsp.rvalid = 1'b1;
      nxt_st.rsp.rdata  = rok ? rd : 32'h0;
      nxt_st.rsp.rresp  = rok ? `GMUX_RESP_OKAY : `GMUX_RESP_SLVERR;
    end
    nxt_st.rsp.arready = !nxt_st.rsp.rvalid;
  end

  always_ff @(posedge aclk) begin : regs
    if (!aresetn) begin
      st_ff             <= '0;
      st_ff.rsp.awready <= 1'b1;
      st_ff.rsp.wready  <= 1'b1;
      st_ff.rsp.arready <= 1'b1;
      st_ff.sel         <= `GMUX_RST_SEL;
      st_ff.gout        <= `GMUX_RST_PIN;
      st_ff.goe         <= `GMUX_RST_PIN;
      st_ff.part_rst_n  <= 4'hf;
      st_ff.irq_n       <= 1'b1;
      st_ff.swo_en      <= `GMUX_RST_NIB;
      // Pins idle high on their pull-ups; starting there avoids a false edge
      st_ff.sync1       <= '1;
      st_ff.sync2       <= '1;
      st_ff.prev        <= '1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign axi_rsp           = st_ff.rsp;
  assign gpio_pin          = st_ff.pins;
  assign partition_reset_n = st_ff.part_rst_n;
  assign switchover_event  = st_ff.swo_evt;
  assign expander_irq_n    = st_ff.irq_n;
  assign stack2_cfg        = st_ff.strap[4:0];
  assign stack3_cfg        = st_ff.strap[9:5];
  assign port_clk_mode     = st_ff.strap[11:10];
  assign refclk_sel        = st_ff.strap[12];

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_gpio_plain: assert property ((st_ff.sel[1:0] == 2'h0) ##1
    (st_ff.sel[1:0] == 2'h0) |-> gpio_pin.oe[0] == $past(st_ff.goe[0]))
    else $error("plain pin oe wrong");
  a_part_in: assert property ((st_ff.sel[3:2] == `GMUX_FN_ALT1
    && !st_ff.sync2[1]) |=> !partition_reset_n[1])
    else $error("partition reset not seen");
  a_part_drv: assert property ((st_ff.sel[5:4] == `GMUX_FN_ALT1
    && st_ff.part_drv[2]) |=> gpio_pin.oe[2] && !gpio_pin.o[2])
    else $error("partition reset not driven");
  a_p16_up: assert property ((st_ff.sel[1:0] == `GMUX_FN_ALT2)
    |=> gpio_pin.oe[0] && gpio_pin.o[0] == !$past(link_up[0]))
    else $error("port 16 link up wrong");
  a_p4_act: assert property ((st_ff.sel[7:6] == `GMUX_FN_ALT2)
    |=> gpio_pin.oe[3] && gpio_pin.o[3] == !$past(link_active[1]))
    else $error("port 4 link active wrong");
  a_p0_up: assert property ((st_ff.sel[9:8] == `GMUX_FN_ALT2)
    |=> gpio_pin.o[4] == !$past(link_up[2]))
    else $error("port 0 link up wrong");
  a_p8_act: assert property ((st_ff.sel[17:16] == `GMUX_FN_ALT2)
    |=> gpio_pin.oe[8] && gpio_pin.o[8] == !$past(link_active[3]))
    else $error("port 8 link active wrong");
  a_swo_edge: assert property ((st_ff.sel[9:8] == `GMUX_FN_ALT1
    && st_ff.swo_en[0] && st_ff.sync2[4] != st_ff.prev[0])
    |=> switchover_event[0] && st_ff.swo_sticky[0])
    else $error("switchover edge missed");
  a_swo_quiet: assert property (switchover_event[2]
    |-> $past(st_ff.swo_en[2]) && $past(st_ff.sel[15:14]) == 2'h1)
    else $error("switchover without enable");
  a_swo_map3: assert property ((st_ff.sel[13:12] == `GMUX_FN_ALT2
    && st_ff.swo_en[3] && st_ff.sync2[6] != st_ff.prev[3])
    |=> switchover_event[3])
    else $error("switchover 3 mapping wrong");
  a_hp_out: assert property ((st_ff.sel[11:10] == `GMUX_FN_ALT1)
    |=> gpio_pin.oe[5] && gpio_pin.o[5] == !$past(hotplug_event))
    else $error("hot-plug event pin wrong");
endmodule // gmux_top
`default_nettype wire

// ==== bench/gmux_board.sv ====
// Board-side model: pin wiring, pull-ups, expander and strap levels
`default_nettype none
module gmux_board #(
  parameter logic [4:0] STK2  = 5'h13,
  parameter logic [4:0] STK3  = 5'h0c,
  parameter logic [1:0] CLKM  = 2'h2,
  parameter logic       FSEL  = 1'h1
) (
  // Device pins and board drivers
  input  wire gmux_pkg::gmux_pin_type pin,
  input  wire logic [8:0]             ext,
  input  wire logic [8:0]             ext_en,
  output logic [8:0]                  gpio_i,
  // Strap levels, static from before reset release
  output logic [4:0]                  stk2,
  output logic [4:0]                  stk3,
  output logic [1:0]                  clkm,
  output logic                        fsel
);
  timeunit 1ns;
  timeprecision 1ps;
  assign gpio_i = ~((pin.oe & ~pin.o) | (ext_en & ~ext));
  assign stk2 = STK2;
  assign stk3 = STK3;
  assign clkm = CLKM;
  assign fsel = FSEL;
endmodule // gmux_board
`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench for the pin mux
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                       aclk = 1'b0;
  logic                       aresetn = 1'b0;
  gmux_pkg::gmux_axi_req_type req = '0;
  gmux_pkg::gmux_axi_rsp_type rsp;
  gmux_pkg::gmux_pin_type     pin;
  logic [8:0]                 gpio_i;
  logic [8:0]                 ext = 9'h1ff;
  logic [8:0]                 ext_en = 9'h000;
  logic [3:0]                 lup = 4'h0;
  logic [3:0]                 lact = 4'h0;
  logic                       hp = 1'b0;
  logic [3:0]                 prst_n;
  logic [3:0]                 swo;
  logic                       irq_n;
  logic [4:0]                 s2, s3, c2, c3;
  logic [1:0]                 cm, ccm;
  logic                       fs, cfs;
  logic [31:0]                rd;
  logic [1:0]                 rr;
  logic [3:0]                 hit;
  int                         mismatches = 0;
  int                         samples_checked = 0;
  int                         cyc = 0;
  always #4 aclk = ~aclk;
  gmux_board i_board (.pin(pin), .ext(ext), .ext_en(ext_en),
    .gpio_i(gpio_i), .stk2(s2), .stk3(s3), .clkm(cm), .fsel(fs));
  gmux_top i_dut (.aclk(aclk), .aresetn(aresetn), .axi_req(req),
    .axi_rsp(rsp), .gpio_i(gpio_i), .gpio_pin(pin), .link_up(lup),
    .link_active(lact), .hotplug_event(hp), .partition_reset_n(prst_n),
    .switchover_event(swo), .expander_irq_n(irq_n),
    .stack2_config_strap(s2), .stack3_config_strap(s3),
    .port_clocking_select(cm), .refclk_freq_select(fs), .stack2_cfg(c2),
    .stack3_cfg(c3), .port_clk_mode(ccm), .refclk_sel(cfs));
  task automatic stop_test;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Bound the run; the whole sequence needs well under 3000 cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr <= {24'h0, a};
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    rr = rsp.bresp;
    req.bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr <= {24'h0, a};
    req.rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    rd = rsp.rdata;
    rr = rsp.rresp;
    req.rready <= 1'b0;
  endtask
  task automatic t_reset;
    repeat (4) @(posedge aclk);
    cmp({ccm, cfs, c3, c2}, {cm, fs, s3, s2});
    axr(8'h18);
    cmp(rd, {19'h0, fs, cm, s3, s2});
    axw(8'h00, 32'h2aaaa);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    cmp({prst_n, irq_n, pin.oe}, {4'hf, 1'b1, 9'h0});
    axr(8'h00);
    cmp(rd, 32'h0);
  endtask
  task automatic t_gpio;
    axw(8'h04, 32'h155);
    axw(8'h08, 32'h1ff);
    repeat (4) @(posedge aclk);
    cmp({pin.oe, pin.o}, {9'h1ff, 9'h155});
    axr(8'h0c);
    cmp(rd, 32'h155);
  endtask
  task automatic t_alt2;
    axw(8'h00, 32'h2aaaa);
    for (int i = 0; i < 2; i++) begin
      lup <= i ? 4'ha : 4'h5;
      lact <= i ? 4'h5 : 4'ha;
      repeat (3) @(posedge aclk);
      cmp(pin.oe, 9'h1bf);
      cmp(pin.o & 9'h1bf, ~{lact[3], lup[3], 1'b0, lact[2], lup[2],
        lact[1], lup[1], lact[0], lup[0]} & 9'h1bf);
    end
  endtask
  task automatic t_alt1;
    axw(8'h00, 32'h15555);
    axw(8'h1c, 32'h5);
    hp <= 1'b1;
    repeat (6) @(posedge aclk);
    cmp({pin.oe, pin.o[5]}, {9'h025, 1'b0});
    cmp(prst_n, 4'ha);
    ext_en <= 9'h10a;
    ext <= 9'h0;
    repeat (6) @(posedge aclk);
    cmp({prst_n, irq_n}, {4'h0, 1'b0});
    ext_en <= 9'h0;
    axw(8'h1c, 32'h0);
  endtask
  task automatic flip(input int p, input logic [3:0] exp);
    hit = 4'h0;
    ext_en[p] <= ~ext_en[p];
    repeat (6) begin
      @(posedge aclk);
      hit = hit | swo;
    end
    cmp(hit, exp);
    axr(8'h14);
    cmp(rd, {28'h0, exp});
    axw(8'h14, 32'hf);
  endtask
  task automatic t_swo;
    axw(8'h10, 32'hf);
    axw(8'h00, 32'h5100);
    repeat (6) @(posedge aclk);
    axw(8'h14, 32'hf);
    flip(4, 4'h1);
    flip(4, 4'h1);
    flip(6, 4'h2);
    flip(7, 4'h4);
    axw(8'h00, 32'h6100);
    flip(6, 4'h8);
    axw(8'h10, 32'h0);
    flip(6, 4'h0);
  endtask
  task automatic t_bad;
    axr(8'h20);
    cmp(rd, 32'h0);
    cmp({30'h0, rr}, 32'h2);
    axr(8'h02);
    cmp({30'h0, rr}, 32'h2);
    axw(8'h24, 32'h1);
    cmp({30'h0, rr}, 32'h2);
  endtask
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_gpio();
    t_alt2();
    t_alt1();
    t_swo();
    t_bad();
    stop_test();
  end
endmodule // testbench
`default_nettype wire
